// File: logic/ssg_pkg.sv
// Constants, register map and types shared by the selector and setting group block
package ssg_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYC_DEF = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int ALARM_TIME_MS = 3000;
  localparam int TICK_MS = TICK_PERIOD_NS / 1000000;
  localparam logic [15:0] ALARM_TICKS = 16'(ALARM_TIME_MS / TICK_MS);

  // Setting groups
  localparam int GROUPS_MAX = 6;
  localparam logic [2:0] GROUP_DEFAULT = 3'h1;

  // Selector positions
  localparam logic [2:0] POS_NONE = 3'h0;
  localparam logic [2:0] POS_FIRST = 3'h1;
  localparam logic [2:0] CODE_REST = 3'h0;

  // APB register offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;

  // Configuration fields
  localparam int CFG_RANGE_LSB = 0;
  localparam int CFG_STEP_ACK_BIT = 3;
  localparam int CFG_CODE_ACK_BIT = 4;
  localparam int CFG_PWR_SYNC_BIT = 5;
  localparam logic [2:0] CFG_RANGE_RST = 3'h7;
  localparam logic [15:0] TIMEOUT_RST = 16'h1388;

  // Status fields
  localparam int ST_POS_LSB = 0;
  localparam int ST_PRESEL_LSB = 4;
  localparam int ST_SEQ_LSB = 8;
  localparam int ST_GROUP_LSB = 12;
  localparam int ST_ALARM_LSB = 16;

  // Interrupt events
  localparam int EVT_N = 6;
  localparam int EVT_APPLIED = 0;
  localparam int EVT_RANGE = 1;
  localparam int EVT_STEP_ALM = 2;
  localparam int EVT_CODE_ALM = 3;
  localparam int EVT_PWR_ALM = 4;
  localparam int EVT_GROUP = 5;

  // Alarm timer slots
  localparam int ALM_N = 4;
  localparam int ALM_RANGE = 0;
  localparam int ALM_STEP = 1;
  localparam int ALM_CODE = 2;
  localparam int ALM_PWR = 3;

  // Selector sequence states
  typedef enum logic [1:0] {
    SEQ_PWRUP,
    SEQ_IDLE,
    SEQ_STEP,
    SEQ_CODE
  } ssg_seq_t;

endpackage

// File: logic/ssg_hold.sv
// Tick-counted hold timer that keeps an alarm level up for a fixed span
`timescale 1ns/1ps
module ssg_hold #(
  parameter int CNT_W = 16
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic tick,
  // Trigger and span
  input wire logic start,
  input wire logic [CNT_W-1:0] span,
  // Level out
  output logic active
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // A new start restarts the full span; otherwise count down on ticks
  assign cnt_d = start ? span :
                 (tick && cnt_q != '0) ? cnt_q - CNT_W'(1) : cnt_q;
  assign active = (cnt_q != '0);

  // Counter register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

endmodule // ssg_hold

// File: logic/ssg_top.sv
// Setting group priority select and multi-position selector switch with APB registers
//
// Functional notes
// - Up to six groups; exactly one active; highest-numbered asserted request wins.
// - Group 1 has no request and is active when no other request is.
// - While the freeze input is high the active group does not change.
// - Each stepping pulse advances the pre-selected position by exactly one.
// - Stepping past the configured upper position wraps back to position 1.
// - A 3-bit coded word pre-selects the position equal to its value.
// - Out-of-range coded word changes nothing and raises range alarm for 3 s.
// - New position stays pre-selected, applied after time-out or on acknowledge.
// - Applied position kept nonvolatile; power-up restores it or follows coded word; reset clears cfg_pwr_sync_q first, so power-up here always restores it.
// - In time-out mode the time-out is the inactivity time before applying.
// - Coded zero is a rest value; codes 1 to 7 select positions in order.
// - Stepping and coded inputs lock each other out during a sequence.
// - Unacknowledged pre-selection is dropped at time-out with a 3 s alarm.
`timescale 1ns/1ps
module ssg_top import ssg_pkg::*; #(
  parameter int NUM_GROUPS = GROUPS_MAX,
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Setting group control
  input wire logic [NUM_GROUPS:2] group_req,
  input wire logic group_change_freeze,
  output logic [2:0] active_group,
  // Selector control inputs
  input wire logic step_in,
  input wire logic step_ack,
  input wire logic coded_select_bit0,
  input wire logic coded_select_bit1,
  input wire logic coded_select_bit2,
  input wire logic coded_ack,
  // Selector outputs
  output logic [2:0] sel_position,
  output logic [2:0] sel_preselect,
  output logic range_alarm,
  output logic step_confirm_alarm,
  output logic bit_confirm_alarm,
  output logic pwr_alarm,
  output logic irq
);

  localparam int TICK_W = $clog2(TICK_CYC + 1);

  // Parameter sanity: group field is three bits wide, tick must exist
  generate
    if (NUM_GROUPS < 2 || NUM_GROUPS > GROUPS_MAX) begin : g_bad_groups
      $error("NUM_GROUPS must lie between 2 and 6");
    end
    if (TICK_CYC < 2) begin : g_bad_tick
      $error("TICK_CYC must be at least 2");
    end
  endgenerate

  // Declarations
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick, cfg_step_ack_q, cfg_code_ack_q, cfg_pwr_sync_q;
  logic [2:0] cfg_range_q, group_q, group_win, pos_q, pos_d, presel_q, presel_d;
  logic [2:0] stored_pos_q = POS_NONE;
  logic [15:0] timeout_q, to_q, to_d, to_load;
  logic [EVT_N-1:0] irq_stat_q, irq_stat_d, irq_mask_q, evt;
  logic [31:0] prdata_q, rd_mux, status_word;
  logic step_prev_q, step_ack_prev_q, code_ack_prev_q;
  logic [2:0] code_prev_q, code_word, step_base, step_next, pwr_src;
  ssg_seq_t seq_q, seq_d;
  logic step_rise, step_ack_rise, code_ack_rise, code_change, code_ok;
  logic to_expire, restart, apply;
  logic [ALM_N-1:0] alm_start, alm_active;
  logic apb_setup, apb_access, addr_hit, wr_cfg, wr_timeout, wr_irq_stat, wr_irq_mask;

  // Periodic tick for all timers, one per millisecond by default
  assign tick = (tick_cnt_q == TICK_W'(TICK_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick_cnt_q <= '0;
    end else if (ce) begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + TICK_W'(1);
    end
  end

  // APB decode; zero wait states, read data captured in setup
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign addr_hit = (paddr == OFS_CFG) || (paddr == OFS_TIMEOUT) || (paddr == OFS_STATUS) ||
                    (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);
  assign wr_cfg = apb_access && pwrite && (paddr == OFS_CFG);
  assign wr_timeout = apb_access && pwrite && (paddr == OFS_TIMEOUT);
  assign wr_irq_stat = apb_access && pwrite && (paddr == OFS_IRQ_STAT);
  assign wr_irq_mask = apb_access && pwrite && (paddr == OFS_IRQ_MASK);
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_hit;
  assign prdata = prdata_q;

  // Status view of the block's own state
  assign status_word = {12'h000, alm_active, 1'b0, group_q, 2'h0, seq_q, 1'b0, presel_q, 1'b0, pos_q};

  // Read selection; every mapped register reads back, unmapped addresses read as zero
  assign rd_mux = (paddr == OFS_CFG) ? {26'h0000000, cfg_pwr_sync_q, cfg_code_ack_q, cfg_step_ack_q,
                                         cfg_range_q} :
                  (paddr == OFS_TIMEOUT) ? {16'h0000, timeout_q} :
                  (paddr == OFS_STATUS) ? status_word :
                  (paddr == OFS_IRQ_STAT) ? {26'h0000000, irq_stat_q} :
                  (paddr == OFS_IRQ_MASK) ? {26'h0000000, irq_mask_q} : 32'h00000000;

  // Read data register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata_q <= 32'h00000000;
    end else if (ce && apb_setup) begin
      prdata_q <= rd_mux;
    end
  end

  // Configuration registers; software steers range, modes and time-out
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_range_q <= CFG_RANGE_RST;
      cfg_step_ack_q <= 1'b0;
      cfg_code_ack_q <= 1'b0;
      cfg_pwr_sync_q <= 1'b0;
      timeout_q <= TIMEOUT_RST;
      irq_mask_q <= '0;
    end else if (ce) begin
      if (wr_cfg) begin
        cfg_range_q <= pwdata[CFG_RANGE_LSB +: 3];
        cfg_step_ack_q <= pwdata[CFG_STEP_ACK_BIT];
        cfg_code_ack_q <= pwdata[CFG_CODE_ACK_BIT];
        cfg_pwr_sync_q <= pwdata[CFG_PWR_SYNC_BIT];
      end
      if (wr_timeout) begin
        timeout_q <= pwdata[15:0];
      end
      if (wr_irq_mask) begin
        irq_mask_q <= pwdata[EVT_N-1:0];
      end
    end
  end

  // Sticky event bits; a new event wins over a write-one clear in the same cycle
  assign irq_stat_d = (irq_stat_q & ~(wr_irq_stat ? pwdata[EVT_N-1:0] : '0)) | evt;
  assign irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_stat_q <= '0;
    end else if (ce) begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // Setting group priority: last asserted request up the list wins
  always_comb begin
    group_win = GROUP_DEFAULT;
    for (int g = 2; g <= NUM_GROUPS; g++) begin
      if (group_req[g]) begin
        group_win = 3'(g);
      end
    end
  end

  // Active group register; freeze holds whatever is in service now
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      group_q <= GROUP_DEFAULT;
    end else if (ce && !group_change_freeze) begin
      group_q <= group_win;
    end
  end

  assign active_group = group_q;

  // Input edge and change detection; inputs are clock synchronous
  assign code_word = {coded_select_bit2, coded_select_bit1, coded_select_bit0};
  assign step_rise = step_in && !step_prev_q;
  assign step_ack_rise = step_ack && !step_ack_prev_q;
  assign code_ack_rise = coded_ack && !code_ack_prev_q;
  assign code_change = (code_word != code_prev_q) && (code_word != CODE_REST);
  assign code_ok = (code_word != CODE_REST) && (code_word <= cfg_range_q);

  // Previous-value registers; reset loads high for the buttons and the rest word for the code, not the pins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      step_prev_q <= 1'b1;
      step_ack_prev_q <= 1'b1;
      code_ack_prev_q <= 1'b1;
      code_prev_q <= CODE_REST;
    end else if (ce) begin
      step_prev_q <= step_in;
      step_ack_prev_q <= step_ack;
      code_ack_prev_q <= coded_ack;
      code_prev_q <= code_word;
    end
  end

  // Stepping starts from the pre-selection inside a sequence, else from the applied position
  assign step_base = (seq_q == SEQ_STEP) ? presel_q : pos_q;
  assign step_next = (step_base == POS_NONE || step_base >= cfg_range_q) ? POS_FIRST :
                     step_base + 3'h1;

  // Time-out counter, restarted by each accepted step pulse or in-range coded word change
  assign to_load = (timeout_q == 16'h0000) ? 16'h0001 : timeout_q;
  assign to_expire = tick && (to_q == 16'h0001) &&
                     (seq_q == SEQ_STEP || seq_q == SEQ_CODE) && !restart;
  assign to_d = restart ? to_load : (tick && to_q != 16'h0000) ? to_q - 16'h0001 : to_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      to_q <= 16'h0000;
    end else if (ce) begin
      to_q <= to_d;
    end
  end

  // Selector sequence; activity wins over an expiry in the same cycle
  assign pwr_src = cfg_pwr_sync_q ? code_word : stored_pos_q;

  always_comb begin
    seq_d = seq_q;
    pos_d = pos_q;
    presel_d = presel_q;
    restart = 1'b0;
    apply = 1'b0;
    alm_start = '0;
    case (seq_q)
      SEQ_PWRUP: begin
        // Out-of-range or rest source gives position 0 and a power alarm
        if (pwr_src != POS_NONE && pwr_src <= cfg_range_q) begin
          pos_d = pwr_src;
        end else begin
          pos_d = POS_NONE;
          alm_start[ALM_PWR] = 1'b1;
        end
        presel_d = pos_d;
        seq_d = SEQ_IDLE;
      end
      SEQ_IDLE: begin
        if (step_rise) begin
          presel_d = step_next;
          restart = 1'b1;
          seq_d = SEQ_STEP;
        end else if (code_change && code_ok) begin
          presel_d = code_word;
          restart = 1'b1;
          seq_d = SEQ_CODE;
        end else if (code_change) begin
          alm_start[ALM_RANGE] = 1'b1;
        end
      end
      SEQ_STEP: begin
        // Coded word is ignored for the whole stepping sequence
        if (step_rise) begin
          presel_d = step_next;
          restart = 1'b1;
        end else if (cfg_step_ack_q && step_ack_rise) begin
          apply = 1'b1;
        end else if (to_expire && !cfg_step_ack_q) begin
          apply = 1'b1;
        end else if (to_expire) begin
          presel_d = pos_q;
          alm_start[ALM_STEP] = 1'b1;
          seq_d = SEQ_IDLE;
        end
      end
      SEQ_CODE: begin
        // Stepping pulses are ignored; a bad word leaves the pre-selection alone
        if (code_change && code_ok) begin
          presel_d = code_word;
          restart = 1'b1;
        end else if (code_change) begin
          alm_start[ALM_RANGE] = 1'b1;
        end else if (cfg_code_ack_q && code_ack_rise) begin
          apply = 1'b1;
        end else if (to_expire && !cfg_code_ack_q) begin
          apply = 1'b1;
        end else if (to_expire) begin
          presel_d = pos_q;
          alm_start[ALM_CODE] = 1'b1;
          seq_d = SEQ_IDLE;
        end
      end
      default: begin
        seq_d = SEQ_IDLE;
      end
    endcase
    if (apply) begin
      pos_d = presel_q;
      seq_d = SEQ_IDLE;
    end
  end

  // Selector state; reset returns to power-up handling
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seq_q <= SEQ_PWRUP;
      pos_q <= POS_NONE;
      presel_q <= POS_NONE;
    end else if (ce) begin
      seq_q <= seq_d;
      pos_q <= pos_d;
      presel_q <= presel_d;
    end
  end

  // Nonvolatile copy; deliberately outside reset so it survives a restart
  always_ff @(posedge clk_sys) begin
    if (ce && apply) begin
      stored_pos_q <= presel_q;
    end
  end

  // Three-second alarm holds, one per alarm source
  generate
    for (genvar a = 0; a < ALM_N; a++) begin : g_alarm
      ssg_hold #(
        .CNT_W(16)
      ) u_hold (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .tick(tick),
        .start(alm_start[a]),
        .span(ALARM_TICKS),
        .active(alm_active[a])
      );
    end
  endgenerate

  assign range_alarm = alm_active[ALM_RANGE];
  assign step_confirm_alarm = alm_active[ALM_STEP];
  assign bit_confirm_alarm = alm_active[ALM_CODE];
  assign pwr_alarm = alm_active[ALM_PWR];

  // Events into the sticky status register
  assign evt[EVT_APPLIED] = ce && apply;
  assign evt[EVT_RANGE] = ce && alm_start[ALM_RANGE];
  assign evt[EVT_STEP_ALM] = ce && alm_start[ALM_STEP];
  assign evt[EVT_CODE_ALM] = ce && alm_start[ALM_CODE];
  assign evt[EVT_PWR_ALM] = ce && alm_start[ALM_PWR];
  assign evt[EVT_GROUP] = ce && !group_change_freeze && (group_win != group_q);

  // Selector outputs come straight from state registers
  assign sel_position = pos_q;
  assign sel_preselect = presel_q;

endmodule // ssg_top

// File: tb/ssg_top_monitor.sv
// Checker for group priority, selector moves and alarm spans at the block ports
`timescale 1ns/1ps
module ssg_top_monitor import ssg_pkg::*; #(
  parameter int NUM_GROUPS = GROUPS_MAX,
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // Setting groups
  input wire logic [NUM_GROUPS:2] group_req,
  input wire logic group_change_freeze,
  input wire logic [2:0] active_group,
  // Selector
  input wire logic coded_select_bit0,
  input wire logic coded_select_bit1,
  input wire logic coded_select_bit2,
  input wire logic [2:0] sel_position,
  input wire logic [2:0] sel_preselect,
  input wire logic range_alarm,
  input wire logic step_confirm_alarm
);
  logic [2:0] grp_exp;
  logic [2:0] code;
  int min_run;
  int rng_run_q;
  int stp_run_q;
  assign code = {coded_select_bit2, coded_select_bit1, coded_select_bit0};
  // The first tick may come right after the start, so allow one tick short
  assign min_run = (int'(ALARM_TICKS) - 1) * TICK_CYC;
  // Highest asserted request, else the default group
  always_comb begin
    grp_exp = GROUP_DEFAULT;
    for (int i = 2; i <= NUM_GROUPS; i++) begin
      if (group_req[i]) begin
        grp_exp = 3'(i);
      end
    end
  end
  // Cycles the range and step alarms have stood high
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rng_run_q <= 0;
      stp_run_q <= 0;
    end else begin
      rng_run_q <= range_alarm ? rng_run_q + 1 : 0;
      stp_run_q <= step_confirm_alarm ? stp_run_q + 1 : 0;
    end
  end
  AST_GROUP_PRIO: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && !group_change_freeze) |=> active_group == $past(grp_exp))
    else $error("active group is not the highest request");
  AST_GROUP_FREEZE: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && group_change_freeze) |=> $stable(active_group))
    else $error("active group moved while frozen");
  AST_GROUP_LEGAL: assert property (@(posedge clk_sys) disable iff (reset)
    active_group >= 3'h1 && active_group <= 3'(NUM_GROUPS))
    else $error("active group out of range");
  AST_APPLY_SRC: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset ##1 !reset ##1 $changed(sel_position)) |-> sel_position == sel_preselect)
    else $error("applied position differs from pre-selection");
  AST_PRESEL_MOVE: assert property (@(posedge clk_sys) disable iff (reset)
    (!reset ##1 !reset ##1 $changed(sel_preselect)) |-> (sel_preselect == $past(code)
    || sel_preselect == $past(sel_preselect) + 3'h1 || sel_preselect == POS_FIRST || sel_preselect == sel_position))
    else $error("pre-selection moved without cause");
  AST_RANGE_CAUSE: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(range_alarm) |-> $past(code) != CODE_REST)
    else $error("range alarm without a nonzero word");
  AST_RANGE_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(range_alarm) |-> rng_run_q >= min_run)
    else $error("range alarm ended early");
  AST_STEP_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(step_confirm_alarm) |-> stp_run_q >= min_run)
    else $error("step alarm ended early");
endmodule // ssg_top_monitor

bind ssg_top ssg_top_monitor #(.NUM_GROUPS(NUM_GROUPS), .TICK_CYC(TICK_CYC)) mon_u (
  .clk_sys(clk_sys), .reset(reset), .ce(ce), .group_req(group_req),
  .group_change_freeze(group_change_freeze), .active_group(active_group),
  .coded_select_bit0(coded_select_bit0), .coded_select_bit1(coded_select_bit1),
  .coded_select_bit2(coded_select_bit2), .sel_position(sel_position), .sel_preselect(sel_preselect),
  .range_alarm(range_alarm), .step_confirm_alarm(step_confirm_alarm)
);

// File: tb/ssg_operands.sv
// Model of the operands, pushbuttons and contact inputs that drive the block
`timescale 1ns/1ps
module ssg_operands #(
  parameter int NUM_GROUPS = 6,
  parameter int TICK_CYC = 10
) (
  // Clock
  input wire logic clk_sys,
  // Group operands
  output logic [NUM_GROUPS:2] group_req,
  output logic group_change_freeze,
  // Pushbuttons
  output logic step_in,
  output logic step_ack,
  output logic coded_ack,
  // Contact inputs of the coded word
  output logic coded_select_bit0,
  output logic coded_select_bit1,
  output logic coded_select_bit2
);
  // With gap set, no pushbutton is pressed again within 50 ms of ticks
  localparam int STEP_GAP = 50 * TICK_CYC;
  initial begin
    group_req = '0;
    group_change_freeze = 1'b0;
    {step_in, step_ack, coded_ack} = 3'h0;
    {coded_select_bit2, coded_select_bit1, coded_select_bit0} = 3'h0;
  end
  // Operand levels change right after an edge
  task automatic set_groups(input logic [NUM_GROUPS:2] req, input logic frz);
    group_req <= req;
    group_change_freeze <= frz;
    @(posedge clk_sys);
  endtask
  // Contacts settle together, bit2 is the most significant
  task automatic set_code(input logic [2:0] c);
    {coded_select_bit2, coded_select_bit1, coded_select_bit0} <= c;
    @(posedge clk_sys);
  endtask
  // Two-cycle pulse: 0 step, 1 step ack, 2 coded ack; the idle edge avoids a double drive
  task automatic press(input int which, input logic gap);
    step_in <= (which == 0);
    step_ack <= (which == 1);
    coded_ack <= (which == 2);
    repeat (2) @(posedge clk_sys);
    {step_in, step_ack, coded_ack} <= 3'h0;
    @(posedge clk_sys);
    if (gap) begin
      repeat (STEP_GAP) @(posedge clk_sys);
    end
  endtask
endmodule // ssg_operands

// File: tb/ssg_top_bench.sv
// Self-checking bench for the setting group and selector block
`timescale 1ns/1ps
module ssg_top_bench import ssg_pkg::*;;
  // Short tick keeps the 3 s alarms affordable
  localparam int TCYC = 10;
  localparam int TO_TICKS = 100;
  logic clk_sys, reset, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [GROUPS_MAX:2] group_req;
  logic group_change_freeze, step_in, step_ack, coded_ack;
  logic coded_select_bit0, coded_select_bit1, coded_select_bit2;
  logic [2:0] active_group, sel_position, sel_preselect;
  logic range_alarm, step_confirm_alarm, bit_confirm_alarm, pwr_alarm;
  int err_count;
  int n_checks;
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  ssg_top #(.TICK_CYC(TCYC)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .group_req(group_req), .group_change_freeze(group_change_freeze), .active_group(active_group),
    .step_in(step_in), .step_ack(step_ack), .coded_select_bit0(coded_select_bit0),
    .coded_select_bit1(coded_select_bit1), .coded_select_bit2(coded_select_bit2), .coded_ack(coded_ack),
    .sel_position(sel_position), .sel_preselect(sel_preselect), .range_alarm(range_alarm),
    .step_confirm_alarm(step_confirm_alarm), .bit_confirm_alarm(bit_confirm_alarm), .pwr_alarm(pwr_alarm),
    .irq(irq)
  );
  ssg_operands #(.NUM_GROUPS(GROUPS_MAX), .TICK_CYC(TCYC)) partner_u (
    .clk_sys(clk_sys), .group_req(group_req), .group_change_freeze(group_change_freeze),
    .step_in(step_in), .step_ack(step_ack), .coded_ack(coded_ack), .coded_select_bit0(coded_select_bit0),
    .coded_select_bit1(coded_select_bit1), .coded_select_bit2(coded_select_bit2)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One APB transfer; an idle edge after it keeps drives one per time step
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    chk(sel_position, POS_NONE, "restored empty position");
    chk(pwr_alarm, 1'b1, "power alarm on empty store");
    apb(1'b0, OFS_CFG, 32'h0, d, e);
    chk(d, 32'h7, "cfg reset");
    apb(1'b0, OFS_TIMEOUT, 32'h0, d, e);
    chk(d, 32'(TIMEOUT_RST), "timeout reset");
    apb(1'b0, 8'h14, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1, "unmapped read");
    apb(1'b1, OFS_TIMEOUT, 32'(TO_TICKS), d, e);
    apb(1'b1, OFS_CFG, 32'h3, d, e);
    apb(1'b0, OFS_TIMEOUT, 32'h0, d, e);
    chk(d, 32'(TO_TICKS), "timeout readback");
    $display("test regs done");
  endtask
  task automatic t_groups();
    logic [31:0] d;
    logic e;
    apb(1'b1, OFS_IRQ_STAT, 32'h3F, d, e);
    apb(1'b1, OFS_IRQ_MASK, 32'h20, d, e);
    for (int i = 2; i <= GROUPS_MAX; i++) begin
      partner_u.set_groups(5'((1 << (i - 1)) - 1), 1'b0);
      cyc(1);
      chk(active_group, 32'(i), "highest request wins");
    end
    chk(irq, 1'b1, "group change interrupt");
    apb(1'b1, OFS_IRQ_STAT, 32'h20, d, e);
    chk(irq, 1'b0, "interrupt cleared");
    partner_u.set_groups(5'h00, 1'b0);
    cyc(1);
    chk(active_group, GROUP_DEFAULT, "default group");
    apb(1'b1, OFS_IRQ_MASK, 32'h0, d, e);
    chk(irq, 1'b0, "interrupt masked");
    partner_u.set_groups(5'h02, 1'b0);
    partner_u.set_groups(5'h10, 1'b1);
    cyc(3);
    chk(active_group, 3'h3, "frozen group");
    partner_u.set_groups(5'h10, 1'b0);
    cyc(1);
    chk(active_group, 3'h6, "released group");
    $display("test groups done");
  endtask
  task automatic t_step();
    logic [2:0] exp_seq [4] = '{3'h1, 3'h2, 3'h3, 3'h1};
    for (int i = 0; i < 4; i++) begin
      partner_u.press(0, 1'b1);
      chk(sel_preselect, exp_seq[i], "step pre-selection");
    end
    cyc(45 * TCYC);
    chk(sel_position, POS_NONE, "held before time-out");
    cyc(10 * TCYC);
    chk(sel_position, 3'h1, "applied at time-out");
    $display("test step done");
  endtask
  task automatic t_code();
    logic [31:0] d;
    logic e;
    partner_u.set_code(3'h2);
    cyc(3);
    chk(sel_preselect, 3'h2, "coded pre-selection");
    partner_u.press(0, 1'b1);
    chk(sel_preselect, 3'h2, "step locked out");
    cyc(55 * TCYC);
    chk(sel_position, 3'h2, "coded position applied");
    partner_u.set_code(CODE_REST);
    cyc(3);
    chk({range_alarm, sel_preselect}, 4'h2, "rest word ignored");
    partner_u.set_code(3'h5);
    cyc(3);
    chk({range_alarm, sel_preselect}, 4'hA, "out of range word");
    cyc(2990 * TCYC);
    chk(range_alarm, 1'b1, "range alarm still up");
    cyc(15 * TCYC);
    chk({range_alarm, sel_position}, 4'h2, "range alarm over");
    apb(1'b0, OFS_IRQ_STAT, 32'h0, d, e);
    chk(d[EVT_RANGE], 1'b1, "range event sticky");
    partner_u.set_code(CODE_REST);
    $display("test code done");
  endtask
  task automatic t_ack();
    logic [31:0] d;
    logic e;
    apb(1'b1, OFS_CFG, 32'h1B, d, e);
    partner_u.press(0, 1'b1);
    chk({sel_preselect, sel_position}, 6'h1A, "awaiting ack");
    partner_u.press(1, 1'b0);
    cyc(1);
    chk(sel_position, 3'h3, "step ack applies");
    partner_u.press(0, 1'b1);
    chk(sel_preselect, 3'h1, "wrap in ack mode");
    cyc(55 * TCYC);
    chk({step_confirm_alarm, sel_preselect, sel_position}, 7'h5B, "ack missing");
    partner_u.set_code(3'h1);
    cyc(3);
    chk({sel_preselect, sel_position}, 6'h0B, "coded awaiting ack");
    partner_u.press(2, 1'b0);
    cyc(1);
    chk(sel_position, 3'h1, "coded ack applies");
    partner_u.set_code(3'h2);
    cyc(105 * TCYC);
    chk({bit_confirm_alarm, sel_preselect, sel_position}, 7'h49, "coded ack missing");
    partner_u.set_code(CODE_REST);
    $display("test ack done");
  endtask
  task automatic t_power();
    logic [31:0] d;
    logic e;
    reset <= 1'b1;
    cyc(2);
    chk({step_confirm_alarm, sel_position}, 4'h0, "cleared in reset");
    cyc(14);
    reset <= 1'b0;
    cyc(3);
    chk({pwr_alarm, sel_position}, 4'h1, "stored position restored");
    apb(1'b0, OFS_CFG, 32'h0, d, e);
    chk(d, 32'h7, "cfg back to reset");
    $display("test power done");
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs about 36400 cycles
  initial begin
    cyc(80000);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
  // Main sequence
  initial begin
    err_count = 0;
    n_checks = 0;
    {reset, ce, psel, penable, pwrite} = 5'h18;
    paddr = '0;
    pwdata = '0;
    cyc(16);
    reset <= 1'b0;
    cyc(3);
    t_regs();
    t_groups();
    t_step();
    t_code();
    t_ack();
    t_power();
    report_and_stop();
  end
endmodule // ssg_top_bench
